/* src/lof_filter.sv */
// Output time-constant filter chain, feedback filter and spectrum record feed
`timescale 1ns/10ps
module lof_filter #(
  parameter int DW   = 24,
  parameter int NTAP = 8,
  parameter int LTAP = 3
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst,
  input  wire lof_pkg::lof_sample_t i_psd,
  input  wire lof_pkg::lof_sample_t i_raw,
  input  wire logic [7:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [31:0]             o_rdata,
  output lof_pkg::lof_sample_t    o_out,
  output lof_pkg::lof_sample_t    o_fb,
  output lof_pkg::lof_fft_t       o_fft
);
  import lof_pkg::*;

  localparam int NP = 4;
  localparam int SW = DW + LTAP;

  // Sample width is fixed by the carrier struct; the tap count must suit the shift
  if (DW != 24 || NTAP != (1 << LTAP) || LTAP < 1) begin : g_bad_params
    $error("lof_filter: DW must be 24 and NTAP a power of two 2**LTAP");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One RC pole; the one-bit-wider difference keeps a bit of headroom
  function automatic logic signed [DW-1:0] rc_step(input logic signed [DW-1:0] y,
                                                  input logic signed [DW-1:0] x,
                                                  input logic [4:0] sh);
    logic signed [DW:0] d;
    logic signed [DW:0] s;
    d = {x[DW-1], x} - {y[DW-1], y};
    s = $signed({y[DW-1], y}) + (d >>> sh);   // Signed sum keeps the shift arithmetic
    rc_step = s[DW-1:0];
  endfunction

  function automatic logic [7:0] tab(input logic [7:0] t [4], input logic [1:0] i);
    tab = t[i];
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic       adv_r, adv_nxt;
  logic [1:0] pole_r, pole_nxt;
  logic [3:0] tc_r, tc_nxt;
  lof_src_t   src_r, src_nxt;
  logic       done_r, done_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  lof_ftype_t ftype;
  logic [4:0] sh;
  logic       rec_end;
  logic [FFT_IDX_W-1:0] cnt_r;

  always_comb begin
    adv_nxt   = adv_r;
    pole_nxt  = pole_r;
    tc_nxt    = tc_r;
    src_nxt   = src_r;
    done_nxt  = done_r;
    rdata_nxt = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        ADDR_CTRL: begin
          adv_nxt  = i_wdata[CTRL_ADV_BIT];
          pole_nxt = i_wdata[CTRL_POLE_LSB +: 2];
          tc_nxt   = i_wdata[CTRL_TC_LSB +: 4];
          if (i_wdata[CTRL_SRC_LSB +: 2] != 2'h3)
            src_nxt = lof_src_t'(i_wdata[CTRL_SRC_LSB +: 2]);
        end
        ADDR_STEP: pole_nxt = pole_r + 2'h1;   // Wraps four back to one
        ADDR_FFT:  if (i_wdata[FFT_DONE_BIT]) done_nxt = 1'b0;
        default: ;
      endcase
    end
    if (rec_end)
      done_nxt = 1'b1;   // Set beats a clear in the same cycle
    if (i_rd) begin
      case (i_addr)
        ADDR_CTRL: begin
          rdata_nxt[CTRL_ADV_BIT]        = adv_r;
          rdata_nxt[CTRL_POLE_LSB +: 2]  = pole_r;
          rdata_nxt[CTRL_TC_LSB +: 4]    = tc_r;
          rdata_nxt[CTRL_SRC_LSB +: 2]   = src_r;
        end
        ADDR_STATUS: begin
          rdata_nxt[STAT_TYPE_LSB +: 2] = ftype;
          rdata_nxt[STAT_POLE_LSB +: 2] = pole_r;
          case (ftype)
            FT_GAUSS: begin
              rdata_nxt[STAT_SETL_LSB +: 8] = tab(SETL_GS, pole_r);
              rdata_nxt[STAT_ENBW_LSB +: 8] = tab(ENBW_GS, pole_r);
            end
            FT_LIN: begin
              rdata_nxt[STAT_SETL_LSB +: 8] = tab(SETL_LP, pole_r);
              rdata_nxt[STAT_ENBW_LSB +: 8] = tab(ENBW_LP, pole_r);
            end
            default: begin
              rdata_nxt[STAT_SETL_LSB +: 8] = tab(SETL_RC, pole_r);
              rdata_nxt[STAT_ENBW_LSB +: 8] = tab(ENBW_RC, pole_r);
            end
          endcase
        end
        ADDR_FFT: begin
          rdata_nxt[FFT_IDX_W-1:0]  = cnt_r;
          rdata_nxt[FFT_DONE_BIT]   = done_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      adv_r   <= RST_ADV;
      pole_r  <= RST_POLE;
      tc_r    <= RST_TC;
      src_r   <= lof_src_t'(RST_SRC);
      done_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      adv_r   <= adv_nxt;
      pole_r  <= pole_nxt;
      tc_r    <= tc_nxt;
      src_r   <= src_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Filter type selection
  // ----------------------------------------------------------------
  always_comb begin
    if (adv_r && tc_r <= TC_GAUSS_MAX)
      ftype = FT_GAUSS;
    else if (adv_r && tc_r >= TC_LIN_MIN && tc_r <= TC_LIN_MAX)
      ftype = FT_LIN;
    else
      ftype = FT_RC;      // Gap between ranges stays RC
  end

  assign sh = {1'b0, tc_r} + 5'h01;

  // ----------------------------------------------------------------
  // RC / linear-phase chain and feedback chain
  // ----------------------------------------------------------------
  logic signed [DW-1:0] rc_r [NP];
  logic signed [DW-1:0] rc_nxt [NP];
  logic signed [DW-1:0] fb_r [NP];
  logic signed [DW-1:0] fb_nxt [NP];
  logic [4:0]           lsh;
  logic [1:0]           prv;

  always_comb begin
    for (int s = 0; s < NP; s++) begin
      rc_nxt[s] = rc_r[s];
      fb_nxt[s] = fb_r[s];
      // Later linear-phase poles run faster; pole one is untouched
      lsh = (ftype == FT_LIN && s != 0 && sh > 5'h01) ? sh - 5'h01 : sh;
      prv = (s == 0) ? 2'h0 : 2'(s - 1);
      if (i_psd.valid) begin
        rc_nxt[s] = rc_step(rc_r[s], (s == 0) ? i_psd.data : rc_r[prv], lsh);
        fb_nxt[s] = rc_step(fb_r[s], (s == 0) ? i_psd.data : fb_r[prv], sh);
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      for (int s = 0; s < NP; s++) begin
        rc_r[s] <= '0;
        fb_r[s] <= '0;
      end
    end else begin
      rc_r <= rc_nxt;
      fb_r <= fb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Gaussian chain: cascaded boxcars, updated once every 2**tc_r input samples
  // ----------------------------------------------------------------
  // A boxcar cascade tends to a Gaussian; the tick rate sets its width so
  // that each stage carries the noise bandwidth of one RC pole.
  logic [15:0]          tick_r, tick_nxt;
  logic                 tick;
  logic signed [DW-1:0] tap_r [NP][NTAP];
  logic signed [DW-1:0] tap_nxt [NP][NTAP];
  logic signed [SW-1:0] sum_r [NP];
  logic signed [SW-1:0] sum_nxt [NP];
  logic signed [DW-1:0] gin;
  logic signed [SW-1:0] gsh;

  assign tick = i_psd.valid && (tick_r == 16'((32'h1 << tc_r) - 32'h1));

  always_comb begin
    tick_nxt = tick_r;
    if (i_psd.valid)
      tick_nxt = tick ? 16'h0000 : tick_r + 16'h0001;
    tap_nxt = tap_r;
    sum_nxt = sum_r;
    for (int s = 0; s < NP; s++) begin
      gsh = sum_r[(s == 0) ? 0 : s-1] >>> LTAP;
      gin = (s == 0) ? i_psd.data : gsh[DW-1:0];   // Identical stages in series
      if (tick) begin
        sum_nxt[s] = sum_r[s] + SW'(gin) - SW'(tap_r[s][NTAP-1]);
        tap_nxt[s][0] = gin;
        for (int k = 1; k < NTAP; k++)
          tap_nxt[s][k] = tap_r[s][k-1];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_r <= 16'h0000;
      for (int s = 0; s < NP; s++) begin
        sum_r[s] <= '0;
        for (int k = 0; k < NTAP; k++)
          tap_r[s][k] <= '0;
      end
    end else begin
      tick_r <= tick_nxt;
      sum_r  <= sum_nxt;
      tap_r  <= tap_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output select and registers
  // ----------------------------------------------------------------
  lof_sample_t out_r, out_nxt;
  lof_sample_t fbo_r, fbo_nxt;
  logic signed [SW-1:0] gsel;

  always_comb begin
    gsel          = sum_nxt[pole_r] >>> LTAP;
    out_nxt.valid = i_psd.valid;
    fbo_nxt.valid = i_psd.valid;
    fbo_nxt.data  = fb_nxt[pole_r];
    if (ftype == FT_GAUSS)
      out_nxt.data = gsel[DW-1:0];
    else
      out_nxt.data = rc_nxt[pole_r];
    if (!i_psd.valid) begin
      out_nxt.data = out_r.data;
      fbo_nxt.data = fbo_r.data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_r <= '0;
      fbo_r <= '0;
    end else begin
      out_r <= out_nxt;
      fbo_r <= fbo_nxt;
    end
  end

  assign o_out = out_r;
  assign o_fb  = fbo_r;

  // ----------------------------------------------------------------
  // Spectrum record feed
  // ----------------------------------------------------------------
  // Only the time record is produced here; the transform takes 1024
  // samples and yields 512 bins, bin zero holding all below 1/record.
  lof_sample_t          fsel;
  lof_fft_t             fft_r, fft_nxt;
  logic [FFT_IDX_W-1:0] cnt_nxt;

  always_comb begin
    case (src_r)   // One source only
      SRC_RAW:  fsel = i_raw;
      SRC_MIX:  fsel = i_psd;
      SRC_FILT: fsel = out_r;
      default:  fsel = '0;
    endcase
    fft_nxt       = fft_r;
    fft_nxt.valid = fsel.valid;
    fft_nxt.last  = 1'b0;
    cnt_nxt       = cnt_r;
    rec_end       = 1'b0;
    if (fsel.valid) begin
      fft_nxt.data = fsel.data;
      fft_nxt.idx  = cnt_r;
      cnt_nxt      = cnt_r + 10'h001;   // Wraps after the record
      if (cnt_r == FFT_IDX_W'(FFT_LEN - 1)) begin
        fft_nxt.last = 1'b1;
        rec_end      = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fft_r <= '0;
      cnt_r <= '0;
    end else begin
      fft_r <= fft_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign o_fft = fft_r;

endmodule // lof_filter

/* src/lof_pkg.sv */
// Shared constants and carrier types for the lock-in output filter block
package lof_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STEP   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FFT    = 8'h0c;

  // CTRL fields
  localparam int CTRL_ADV_BIT   = 0;
  localparam int CTRL_POLE_LSB  = 1;
  localparam int CTRL_TC_LSB    = 4;
  localparam int CTRL_SRC_LSB   = 8;
  // STATUS fields
  localparam int STAT_TYPE_LSB  = 0;
  localparam int STAT_POLE_LSB  = 2;
  localparam int STAT_SETL_LSB  = 8;
  localparam int STAT_ENBW_LSB  = 16;
  // FFT fields
  localparam int FFT_DONE_BIT   = 16;

  // Reset values
  localparam logic       RST_ADV   = 1'b0;
  localparam logic [1:0] RST_POLE  = 2'h0;
  localparam logic [3:0] RST_TC    = 4'h0;
  localparam logic [1:0] RST_SRC   = 2'h0;

  // ----------------------------------------------------------------
  // Time constant codes and range limits
  // ----------------------------------------------------------------
  localparam logic [3:0] TC_GAUSS_MAX = 4'h8;   // 3 s
  localparam logic [3:0] TC_LIN_MIN   = 4'ha;   // 10 s
  localparam logic [3:0] TC_LIN_MAX   = 4'hf;   // 30000 s

  // Spectrum record
  localparam int FFT_LEN    = 1024;
  localparam int FFT_BINS   = FFT_LEN / 2;
  localparam int FFT_IDX_W  = 10;

  // ----------------------------------------------------------------
  // Settling (tenths of a time constant) and noise bandwidth (hundredths)
  // ----------------------------------------------------------------
  localparam logic [7:0] SETL_RC  [4] = '{8'h2e, 8'h42, 8'h54, 8'h64};
  localparam logic [7:0] SETL_GS  [4] = '{8'h17, 8'h28, 8'h38, 8'h47};
  localparam logic [7:0] SETL_LP  [4] = '{8'h2e, 8'h2c, 8'h30, 8'h36};
  localparam logic [7:0] ENBW_RC  [4] = '{8'ha0, 8'h4f, 8'h3b, 8'h32};
  localparam logic [7:0] ENBW_GS  [4] = '{8'ha0, 8'h6e, 8'h5e, 8'h51};
  localparam logic [7:0] ENBW_LP  [4] = '{8'ha0, 8'h5d, 8'h53, 8'h4e};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FT_RC    = 2'b00,
    FT_GAUSS = 2'b01,
    FT_LIN   = 2'b10
  } lof_ftype_t;

  typedef enum logic [1:0] {
    SRC_RAW  = 2'b00,
    SRC_MIX  = 2'b01,
    SRC_FILT = 2'b10
  } lof_src_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] data;
  } lof_sample_t;

  typedef struct packed {
    logic                 valid;
    logic                 last;
    logic [FFT_IDX_W-1:0] idx;
    logic [23:0]          data;
  } lof_fft_t;

endpackage

/* dv/lof_properties.sv */
// Port-level checks for the lock-in output filter block
`timescale 1ns/10ps
module lof_properties (
  input wire logic                 i_clk_sys,
  input wire logic                 i_rst,
  input wire lof_pkg::lof_sample_t i_psd,
  input wire lof_pkg::lof_sample_t i_raw,
  input wire logic [7:0]           i_addr,
  input wire logic [31:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [31:0]          o_rdata,
  input wire lof_pkg::lof_sample_t o_out,
  input wire lof_pkg::lof_sample_t o_fb,
  input wire lof_pkg::lof_fft_t    o_fft
);
  import lof_pkg::*;
  // ----
  // Shadow control state
  // ----
  logic       adv_r;
  logic [3:0] tc_r;
  logic [1:0] pole_r;
  logic [1:0] src_r;
  lof_ftype_t typ;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      adv_r  <= RST_ADV;
      tc_r   <= RST_TC;
      pole_r <= RST_POLE;
      src_r  <= RST_SRC;
    end else if (i_wr && i_addr == ADDR_CTRL) begin
      adv_r  <= i_wdata[CTRL_ADV_BIT];
      pole_r <= i_wdata[CTRL_POLE_LSB+:2];
      tc_r   <= i_wdata[CTRL_TC_LSB+:4];
      // Source code 3 is refused, old source kept
      if (i_wdata[CTRL_SRC_LSB+:2] != 2'h3) begin
        src_r <= i_wdata[CTRL_SRC_LSB+:2];
      end
    end else if (i_wr && i_addr == ADDR_STEP) begin
      pole_r <= pole_r + 2'h1;
    end
  end
  always_comb begin
    typ = FT_RC;
    if (adv_r && tc_r <= TC_GAUSS_MAX) typ = FT_GAUSS;
    if (adv_r && tc_r >= TC_LIN_MIN) typ = FT_LIN;
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  sequence s_stat_rd;
    i_rd && i_addr == ADDR_STATUS;
  endsequence
  sequence s_filt;
    i_psd.valid && src_r == SRC_FILT ##1 o_out.valid;
  endsequence
  property p_type;
    s_stat_rd |=> o_rdata[1:0] == $past(typ);
  endproperty
  a_type: assert property (p_type) else $error("status type wrong");
  property p_pole;
    s_stat_rd |=> o_rdata[3:2] == $past(pole_r);
  endproperty
  a_pole: assert property (p_pole) else $error("status poles wrong");
  property p_fb;
    i_psd.valid |=> o_fb.valid && o_out.valid;
  endproperty
  a_fb: assert property (p_fb) else $error("output missing");
  property p_spur;
    o_fb.valid |-> $past(i_psd.valid);
  endproperty
  a_spur: assert property (p_spur) else $error("spurious feedback");
  property p_lin1;
    i_psd.valid && typ == FT_LIN && pole_r == 2'h0 |=> o_out.data == o_fb.data;
  endproperty
  a_lin1: assert property (p_lin1) else $error("linear pole differs");
  property p_rcfb;
    i_psd.valid && typ == FT_RC |=> o_out.data == o_fb.data;
  endproperty
  a_rcfb: assert property (p_rcfb) else $error("plain mode differs");
  property p_fraw;
    i_raw.valid && src_r == SRC_RAW |=> o_fft.valid && o_fft.data == $past(i_raw.data);
  endproperty
  a_fraw: assert property (p_fraw) else $error("raw feed wrong");
  property p_fmix;
    i_psd.valid && src_r == SRC_MIX |=> o_fft.valid && o_fft.data == $past(i_psd.data);
  endproperty
  a_fmix: assert property (p_fmix) else $error("mixer feed wrong");
  property p_ffilt;
    s_filt |=> o_fft.valid && o_fft.data == $past(o_out.data);
  endproperty
  a_ffilt: assert property (p_ffilt) else $error("filtered feed wrong");
  property p_last;
    o_fft.valid |-> o_fft.last == (o_fft.idx == 10'h3ff);
  endproperty
  a_last: assert property (p_last) else $error("record end wrong");
endmodule // lof_properties

/* dv/lof_stream_src.sv */
// Detector and converter sample source model
`timescale 1ns/10ps
module lof_stream_src (
  input  wire logic           i_clk_sys,
  output lof_pkg::lof_sample_t o_psd,
  output lof_pkg::lof_sample_t o_raw
);
  import lof_pkg::*;
  initial begin
    o_psd = '0;
    o_raw = '0;
  end
  // ----
  // One sample per call
  // ----
  // Idle data is inverted so a stale value never passes as fresh
  task automatic send(input logic raw, input logic [23:0] d);
    @(posedge i_clk_sys);
    if (raw) o_raw <= '{1'b1, d};
    else o_psd <= '{1'b1, d};
    @(posedge i_clk_sys);
    if (raw) o_raw <= '{1'b0, ~d};
    else o_psd <= '{1'b0, ~d};
  endtask
endmodule // lof_stream_src

/* dv/lof_filter_bench.sv */
// Self-checking bench for the lock-in output filter block
`timescale 1ns/10ps
module lof_filter_bench;
  import lof_pkg::*;
  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  lof_sample_t i_psd;
  lof_sample_t i_raw;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  lof_sample_t o_out;
  lof_sample_t o_fb;
  lof_fft_t    o_fft;
  int          miscompares = 0;
  int          checks_done = 0;
  logic [31:0] rv;
  int          s[4];
  int          tcs[5] = '{0, 8, 9, 10, 15};
  logic [7:0]  setl[3][4] = '{'{8'h2e, 8'h42, 8'h54, 8'h64}, '{8'h17, 8'h28, 8'h38, 8'h47},
                              '{8'h2e, 8'h2c, 8'h30, 8'h36}};
  logic [7:0]  enbw[3][4] = '{'{8'ha0, 8'h4f, 8'h3b, 8'h32}, '{8'ha0, 8'h6e, 8'h5e, 8'h51},
                              '{8'ha0, 8'h5d, 8'h53, 8'h4e}};
  always #2 i_clk_sys = ~i_clk_sys;
  lof_stream_src u_src (.i_clk_sys, .o_psd(i_psd), .o_raw(i_raw));
  lof_filter uut (.i_clk_sys, .i_rst, .i_psd, .i_raw, .i_addr, .i_wdata, .i_wr, .i_rd,
                  .o_rdata, .o_out, .o_fb, .o_fft);
  // ----
  // Access and compare tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic do_reset;
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_rst <= 1'b0;
  endtask
  // Step input through RC chain model; main output also compared when same is set
  task automatic filt(input logic [31:0] ctrl, input int n, input logic same);
    int sh;
    int pl;
    int p;
    do_reset();
    wr(ADDR_CTRL, ctrl);
    sh = int'(ctrl[7:4]) + 1;
    pl = int'(ctrl[2:1]);
    s = '{default: 0};
    for (int i = 0; i < n; i++) begin
      u_src.send(1'b0, 24'h01_0000);
      // Each stage sees the previous stage's value from the last sample
      for (int k = 3; k >= 0; k--) begin
        p = (k == 0) ? 'h1_0000 : s[(k == 0) ? 0 : k - 1];
        s[k] += (p - s[k]) >>> sh;
      end
      #1 chk(o_fb.data, s[pl][23:0]);
      if (same) chk(o_out.data, s[pl][23:0]);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    int ty;
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(ADDR_CTRL, rv);
    chk(rv, 32'h0000_0000);
    for (int a = 0; a < 2; a++) begin
      for (int t = 0; t < 5; t++) begin
        for (int p = 0; p < 4; p++) begin
          wr(ADDR_CTRL, {24'h00_0000, 4'(tcs[t]), 1'b0, 2'(p), 1'(a)});
          rd(ADDR_STATUS, rv);
          ty = (a == 1 && tcs[t] <= 8) ? 1 : (a == 1 && tcs[t] >= 10) ? 2 : 0;
          chk(rv, {8'h00, enbw[ty][p], setl[ty][p], 4'h0, 2'(p), 2'(ty)});
        end
      end
    end
    wr(ADDR_CTRL, 32'h0000_0000);
    for (int i = 1; i < 6; i++) begin
      wr(ADDR_STEP, 32'h0000_0000);
      rd(ADDR_STATUS, rv);
      chk(rv[3:2], 32'(i % 4));
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, rv);
    chk(rv, 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0100);
    wr(ADDR_CTRL, 32'h0000_0300);
    rd(ADDR_CTRL, rv);
    chk(rv, 32'h0000_0100);
    u_src.send(1'b0, 24'h00_0abc);
    #1 chk({o_fft.valid, o_fft.data}, {1'b1, 24'h00_0abc});
    u_src.send(1'b1, 24'h00_0123);
    #1 chk(o_fft.valid, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0200);
    u_src.send(1'b0, 24'h00_0777);
    @(posedge i_clk_sys);
    #1 chk({o_fft.valid, o_fft.data}, {1'b1, 24'h00_066a});
    do_reset();
    for (int i = 0; i < 1024; i++) begin
      u_src.send(1'b1, 24'(i * 5));
      #1 chk({o_fft.last, o_fft.idx, o_fft.data[19:0]}, {i == 1023, 10'(i), 20'(i * 5)});
    end
    rd(ADDR_FFT, rv);
    chk(rv, 32'h0001_0000);
    wr(ADDR_FFT, 32'h0001_0000);
    rd(ADDR_FFT, rv);
    chk(rv, 32'h0000_0000);
    filt(32'h0000_0016, 12, 1'b1);
    filt(32'h0000_00a1, 8, 1'b1);
    filt(32'h0000_0093, 6, 1'b1);
    filt(32'h0000_0007, 40, 1'b0);
    chk(o_out.data, 24'h01_0000);
    final_report();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge i_clk_sys);
    miscompares++;
    $display("ERROR %0t run limit reached", $time);
    final_report();
  end
endmodule // lof_filter_bench

bind lof_filter lof_properties u_props (.i_clk_sys, .i_rst, .i_psd, .i_raw, .i_addr, .i_wdata,
                                        .i_wr, .i_rd, .o_rdata, .o_out, .o_fb, .o_fft);
